// file: dcs_top.sv
// Purpose: command sequencer of a cartridge disk controller behind an APB slave
// Assumes: drive link as byte streams and word handshakes, all synchronous to pclk
// Notes: one state struct, one always_comb, two always_ff (state register and silo storage)
// Functional notes
// - get status puts the drive's 16-bit status in two silo bytes
// - seek sends cmd a direction, head and difference with drive select
// - after sending a seek the block is ready again at once
// - the drive itself backs out of the guard band onto an even track
// - read header stores the six header bytes, checked, in six silo words
// - write fetches words by dma, stepping pointer and counter until zero
// - write hunts checked headers with crc until the wanted one, then writes
// - no implicit seek; header never found raises operation incomplete
// - partial sectors are zero filled and every sector gets a 16-bit crc
// - count reaches 4096 words; 12-bit mode moves at most one 170-word sector
// - no seek in mid transfer; each command stays on the current track
// - read data fills memory by dma from the wanted sector until count zero
// - read data starts only after a crc-checked header matches the address
// - read data checks the data crc of every sector
// - read without header check takes the first header after command start as a match; later sectors need a checked match
// - maintenance bit loops the drive command word into the silo as two bytes
// - drive command word bits with several sources take their logical or
// - each silo read returns one silo word
// - 8-bit mode bytes sit in the low bits with the top four bits zero
// - interrupt when enabled and done; every error also sets done
//
// The implementer's own choices: the address map and the APB register port.
`timescale 1ns/10ps
`include "dcs_regs.svh"
module dcs_top import dcs_pkg::*; #(
  parameter logic [7:0] HDR_LIMIT = 8'd40
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output dcs_word_t drv_cmd,
  input wire logic drv_cmd_ready,
  input wire dcs_word_t drv_stat,
  input wire dcs_byte_t dsk_rx,
  input wire logic dsk_rx_sof,
  output dcs_byte_t dsk_tx,
  input wire logic dsk_tx_ready,
  output dcs_dma_t dma,
  input wire logic dma_ack,
  input wire logic [11:0] dma_rdata
);
  dcs_st_t s_q, s_d;
  logic [11:0] silo_mem [2**`DCS_SILO_AW];
  logic acc, fin, fin_cmd, push_en, pop_en, need, zero, hok, empty, mode8;
  logic [11:0] push_val, head, wv;
  logic [15:0] crc_n;
  logic [2:0] hid;
  logic [7:0] tb;
  logic [`DCS_SILO_AW:0] cnt;
  dcs_func_t fn;

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  // crc-16 over one byte, msb first
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      r = r[15] ? ((r << 1) ^ `DCS_CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  // silo occupancy and head word
  assign cnt = s_q.wptr - s_q.rptr;
  assign empty = (cnt == '0);
  assign head = silo_mem[s_q.rptr[`DCS_SILO_AW-1:0]];
  assign fn = dcs_func_t'(s_q.cmdb[`DCS_B_FUNC]);
  assign mode8 = s_q.cmdb[`DCS_B_MODE8];

  // outputs straight from the state flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign irq = s_q.irq;
  assign drv_cmd = s_q.cmd;
  assign dsk_tx = s_q.tx;
  assign dma = s_q.dma;

  // -----------------------------------------------------------------------
  // next state
  // -----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    fin_cmd = 1'b0;
    push_en = 1'b0;
    pop_en = 1'b0;
    push_val = `DCS_WORD0;
    need = 1'b0;
    zero = 1'b0;
    hok = 1'b0;
    wv = `DCS_WORD0;
    tb = 8'h00;
    hid = 3'd0;
    crc_n = crc_byte(s_q.crc, dsk_rx.data);
    // apb: one wait state, decode at access start, act at completion
    acc = psel & penable;
    fin = acc & s_q.pready;
    s_d.pready = acc & ~s_q.pready;
    if (acc & ~s_q.pready) begin
      s_d.pslverr = 1'b0;
      unique case (paddr)
        `DCS_OFF_MEMPTR: s_d.prdata = 32'(s_q.memptr);
        `DCS_OFF_SECTOR: s_d.prdata = 32'(s_q.sector);
        `DCS_OFF_WCOUNT: s_d.prdata = 32'(s_q.wc);
        `DCS_OFF_CMDA: s_d.prdata = 32'(s_q.cmda);
        `DCS_OFF_CMDB: s_d.prdata = 32'(s_q.cmdb);
        `DCS_OFF_STATUS: s_d.prdata = 32'({s_q.cmdb[`DCS_B_DRIVE], ~empty, s_q.dlt, s_q.dcrc,
          s_q.hcrc, s_q.operation_incomplete_error, s_q.done, ~s_q.busy});
        `DCS_OFF_SILO: s_d.prdata = empty ? 32'h0000_0000 : 32'(head);
        default: begin
          s_d.prdata = 32'h0000_0000;
          s_d.pslverr = 1'b1;
        end
      endcase
    end
    // register writes only while ready
    if (fin & ~s_q.pslverr & pwrite & ~s_q.busy) begin
      unique case (paddr)
        `DCS_OFF_MEMPTR: s_d.memptr = pwdata[`DCS_WORD_BITS];
        `DCS_OFF_SECTOR: s_d.sector = pwdata[`DCS_WORD_BITS];
        `DCS_OFF_WCOUNT: s_d.wc = pwdata[`DCS_WORD_BITS];
        `DCS_OFF_CMDA: s_d.cmda = pwdata[`DCS_WORD_BITS];
        `DCS_OFF_CMDB: begin
          // command start: flush silo, clear flags, build the drive command word
          s_d.cmdb = pwdata[`DCS_WORD_BITS];
          s_d.busy = 1'b1;
          s_d.done = 1'b0;
          s_d.operation_incomplete_error = 1'b0;
          s_d.hcrc = 1'b0;
          s_d.dcrc = 1'b0;
          s_d.dlt = 1'b0;
          s_d.dcw = {4'h0, s_q.cmda} | {s_q.sector[`DCS_SA_SEC], 10'h000} |
            16'(pwdata[`DCS_B_FUNC]) | 16'(pwdata[`DCS_B_DRIVE]);
          s_d.cmd.valid = 1'b1;
          s_d.cmd.word = s_d.dcw;
          s_d.state = ST_SEND;
          s_d.ph = 2'd0;
          s_d.wptr = s_q.rptr;
          s_d.hcnt = 8'd0;
          s_d.hidx = 3'd0;
          s_d.first = 1'b1;
          s_d.xfer_on = 1'b1; // a zero count means 4096 words
          s_d.push_on = 1'b1;
          s_d.wpush = s_q.wc;
        end
        default: ;
      endcase
    end
    // each silo read pops one word while idle
    if (fin & ~s_q.pslverr & ~pwrite & (paddr == `DCS_OFF_SILO) & ~empty &
        (s_q.state == ST_IDLE)) begin
      pop_en = 1'b1;
    end
    // command sequencing
    unique case (s_q.state)
      ST_IDLE: ;
      ST_SEND: begin
        if (drv_cmd_ready) begin
          // seek motion, including guard band retreat, is left to the drive
          s_d.cmd.valid = 1'b0;
          unique case (fn)
            FN_GSTAT: s_d.nxt = ST_STAT;
            FN_RHDR, FN_WDAT, FN_RDAT, FN_RDNH: s_d.nxt = ST_HDR;
            FN_MAINT, FN_RESET, FN_SEEK: s_d.nxt = ST_IDLE;
          endcase
          if (s_q.cmdb[`DCS_B_MAINT]) begin
            s_d.state = ST_PAIR;
          end else if (s_d.nxt == ST_IDLE) begin
            fin_cmd = 1'b1;
          end else begin
            s_d.state = s_d.nxt;
          end
        end
      end
      ST_PAIR: begin
        // two silo bytes, high byte first
        push_en = 1'b1;
        if (s_q.ph == 2'd0) begin
          push_val = {4'h0, s_q.dcw[15:8]};
          s_d.ph = 2'd1;
        end else begin
          push_val = {4'h0, s_q.dcw[7:0]};
          s_d.ph = 2'd0;
          if (s_q.nxt == ST_IDLE) begin
            fin_cmd = 1'b1;
          end else begin
            s_d.state = s_q.nxt;
          end
        end
      end
      ST_STAT: begin
        if (drv_stat.valid) begin
          s_d.dcw = drv_stat.word;
          s_d.nxt = ST_IDLE;
          s_d.state = ST_PAIR;
        end
      end
      ST_HDR: begin
        if (dsk_rx.valid & (dsk_rx_sof | (s_q.hidx != 3'd0))) begin
          crc_n = crc_byte(dsk_rx_sof ? `DCS_CRC_INIT : s_q.crc, dsk_rx.data);
          s_d.crc = crc_n;
          hid = dsk_rx_sof ? 3'd0 : s_q.hidx;
          if (hid == 3'd0) begin
            s_d.haddr[15:8] = dsk_rx.data;
          end
          if (hid == 3'd1) begin
            s_d.haddr[7:0] = dsk_rx.data;
          end
          if (fn == FN_RHDR) begin
            push_en = 1'b1;
            push_val = {4'h0, dsk_rx.data};
          end
          s_d.hidx = hid + 3'd1;
          if (hid == `DCS_HDR_LAST) begin
            s_d.hidx = 3'd0;
            hok = (crc_n == `DCS_CRC_GOOD);
            if (fn == FN_RHDR) begin
              s_d.hcrc = ~hok;
              fin_cmd = 1'b1;
            end else if (((fn == FN_RDNH) & s_q.first) | (hok & (s_q.haddr ==
                {s_q.cmda[`DCS_A_CYL], s_q.sector[`DCS_SA_SEC]}))) begin
              s_d.state = (fn == FN_WDAT) ? ST_WDAT : ST_RDAT;
              s_d.bidx = 9'd0;
              s_d.ph = 2'd0;
              s_d.crc = `DCS_CRC_INIT;
              s_d.first = 1'b0;
            end else if (~hok) begin
              s_d.hcrc = 1'b1;
              fin_cmd = 1'b1;
            end else begin
              s_d.hcnt = s_q.hcnt + 8'd1;
              if (s_d.hcnt == HDR_LIMIT) begin
                s_d.operation_incomplete_error = 1'b1;
                fin_cmd = 1'b1;
              end
            end
          end
        end
      end
      ST_RDAT: begin
        if (dsk_rx.valid) begin
          s_d.crc = crc_n;
          s_d.bidx = s_q.bidx + 9'd1;
          if ((s_q.bidx <= `DCS_DAT_LAST) & s_q.push_on) begin
            if (mode8) begin
              push_en = 1'b1;
              push_val = {4'h0, dsk_rx.data};
            end else if (s_q.bidx != `DCS_DAT_LAST) begin
              // three bytes pack into two 12-bit words
              unique case (s_q.ph)
                2'd0: begin
                  s_d.hold = {4'h0, dsk_rx.data};
                  s_d.ph = 2'd1;
                end
                2'd1: begin
                  push_en = 1'b1;
                  push_val = {s_q.hold[7:0], dsk_rx.data[7:4]};
                  s_d.hold = {8'h00, dsk_rx.data[3:0]};
                  s_d.ph = 2'd2;
                end
                2'd2: begin
                  push_en = 1'b1;
                  push_val = {s_q.hold[3:0], dsk_rx.data};
                  s_d.ph = 2'd0;
                end
                default: s_d.ph = 2'd0;
              endcase
            end
          end
          if (push_en) begin
            s_d.wpush = s_q.wpush + 12'h001;
            s_d.push_on = (s_d.wpush != `DCS_WORD0);
          end
          if (push_en & cnt[`DCS_SILO_AW]) begin
            push_en = 1'b0;
            s_d.dlt = 1'b1;
            fin_cmd = 1'b1;
          end else if (s_q.bidx == `DCS_SEC_LAST) begin
            if (crc_n != `DCS_CRC_GOOD) begin
              s_d.dcrc = 1'b1;
              fin_cmd = 1'b1;
            end else begin
              s_d.sector = s_q.sector + 12'h001;
              s_d.hidx = 3'd0;
              s_d.hcnt = 8'd0;
              s_d.state = (~mode8 | ~s_d.push_on) ? ST_DRN : ST_HDR;
            end
          end
        end
      end
      ST_WDAT: begin
        if (~s_q.tx.valid | dsk_tx_ready) begin
          s_d.tx.valid = 1'b0;
          if (s_q.bidx == `DCS_SEC_END) begin
            s_d.sector = s_q.sector + 12'h001;
            s_d.hidx = 3'd0;
            s_d.hcnt = 8'd0;
            if (~mode8 | (~s_q.xfer_on & empty)) begin
              fin_cmd = 1'b1;
            end else begin
              s_d.state = ST_HDR;
            end
          end else if (s_q.bidx >= `DCS_CRC_HI) begin
            s_d.tx.valid = 1'b1;
            s_d.tx.data = (s_q.bidx == `DCS_CRC_HI) ? s_q.crc[15:8] : s_q.crc[7:0];
            s_d.bidx = s_q.bidx + 9'd1;
          end else begin
            need = mode8 | (s_q.ph != 2'd2);
            zero = (~mode8 & (s_q.bidx == `DCS_DAT_LAST)) | (~s_q.xfer_on & empty);
            if (~(need & ~zero & empty)) begin
              wv = (need & ~zero) ? head : `DCS_WORD0;
              pop_en = need & ~zero;
              if (mode8) begin
                tb = wv[7:0];
              end else begin
                unique case (s_q.ph)
                  2'd0: tb = wv[11:4];
                  2'd1: tb = {s_q.hold[3:0], wv[11:8]};
                  2'd2: tb = s_q.hold[7:0];
                  default: tb = 8'h00;
                endcase
                s_d.hold = (s_q.ph == 2'd2) ? s_q.hold : wv;
                s_d.ph = (s_q.ph == 2'd2) ? 2'd0 : s_q.ph + 2'd1;
              end
              s_d.tx.valid = 1'b1;
              s_d.tx.data = tb;
              s_d.crc = crc_byte(s_q.crc, tb);
              s_d.bidx = s_q.bidx + 9'd1;
            end
          end
        end
      end
      ST_DRN: begin
        if (~s_q.xfer_on) begin
          fin_cmd = 1'b1;
        end
      end
    endcase
    // dma engine: write fetches into the silo, read drains it to memory
    if (s_q.dma.req & dma_ack) begin
      s_d.dma.req = 1'b0;
      s_d.memptr = s_q.memptr + 12'h001;
      s_d.wc = s_q.wc + 12'h001;
      s_d.xfer_on = (s_d.wc != `DCS_WORD0);
      if (~s_q.dma.we) begin
        push_en = 1'b1;
        push_val = dma_rdata;
      end
    end else if (~s_q.dma.req & s_q.xfer_on) begin
      if ((fn == FN_WDAT) & ((s_q.state == ST_HDR) | (s_q.state == ST_WDAT)) &
          (cnt < `DCS_SILO_LIM)) begin
        s_d.dma.req = 1'b1;
        s_d.dma.we = 1'b0;
        s_d.dma.addr = {s_q.cmdb[`DCS_B_EXT], s_q.memptr};
      end else if (((fn == FN_RDAT) | (fn == FN_RDNH)) & ~empty &
          ((s_q.state == ST_RDAT) | (s_q.state == ST_DRN) | (s_q.state == ST_HDR))) begin
        pop_en = 1'b1;
        s_d.dma.req = 1'b1;
        s_d.dma.we = 1'b1;
        s_d.dma.addr = {s_q.cmdb[`DCS_B_EXT], s_q.memptr};
        s_d.dma.wdata = head;
      end
    end
    // finishing a command; errors finish it too
    if (fin_cmd) begin
      s_d.state = ST_IDLE;
      s_d.busy = 1'b0;
      s_d.done = 1'b1;
    end
    // silo pointers move in order of arrival
    if (push_en) begin
      s_d.wptr = s_d.wptr + 5'd1;
    end
    if (pop_en) begin
      s_d.rptr = s_d.rptr + 5'd1;
    end
    s_d.irq = s_q.cmdb[`DCS_B_IE] & s_q.done;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // silo storage, written at the tail
  always_ff @(posedge pclk) begin
    if (push_en) begin
      silo_mem[s_q.wptr[`DCS_SILO_AW-1:0]] <= push_val;
    end
  end

  // -----------------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence push_one;
    ##1 (cnt == $past(cnt) + 1'b1);
  endsequence
  a_gstat_two_bytes: assert property ((s_q.state == ST_STAT) & drv_stat.valid |->
    ##1 push_one ##1 (cnt == $past(cnt, 2) + 5'd2))
    else $error("status not placed as two silo words");
  a_busy_no_load: assert property (fin & pwrite & s_q.busy |=> $stable(s_q.cmda) &
    (s_q.memptr == $past(s_q.memptr) + 12'($past(s_q.dma.req & dma_ack)))) else
    $error("setup register changed while busy");
  a_seek_ready: assert property ((s_q.state == ST_SEND) & drv_cmd_ready & (fn == FN_SEEK) &
    ~s_q.cmdb[`DCS_B_MAINT] |=> ~s_q.busy & s_q.done) else $error("seek did not return ready");
  a_dma_step: assert property (s_q.dma.req & dma_ack |=> (s_q.wc == $past(s_q.wc) + 12'h001) &&
    (s_q.memptr == $past(s_q.memptr) + 12'h001)) else $error("pointer or count did not step");
  a_low_byte: assert property (push_en & ((s_q.state == ST_PAIR) |
    ((s_q.state == ST_HDR) & (fn == FN_RHDR)) | ((s_q.state == ST_RDAT) & mode8)) |->
    push_val[11:8] == 4'h0) else $error("upper bits set");
  a_loop_high: assert property ((s_q.state == ST_PAIR) & (s_q.ph == 2'd0) |->
    push_val == {4'h0, s_q.dcw[15:8]} ##1 push_val == {4'h0, s_q.dcw[7:0]})
    else $error("loopback bytes out of order");
  a_err_done: assert property ($rose(s_q.operation_incomplete_error | s_q.hcrc | s_q.dcrc | s_q.dlt) |->
    s_q.done & ~s_q.busy) else $error("error without done");
  a_irq_cause: assert property (s_q.irq |-> $past(s_q.done & s_q.cmdb[`DCS_B_IE]))
    else $error("interrupt without cause");
  a_opi_limit: assert property ($rose(s_q.operation_incomplete_error) |-> $past(s_q.hcnt) == HDR_LIMIT - 8'd1)
    else $error("operation incomplete at wrong header count");
  a_crc_tail: assert property ((s_q.state == ST_WDAT) & (s_q.bidx == `DCS_CRC_HI) &
    (~s_q.tx.valid | dsk_tx_ready) |=> s_q.tx.valid & (s_q.tx.data == $past(s_q.crc[15:8])))
    else $error("crc high byte not sent");
endmodule

// file: dcs_regs.svh
// Purpose: register offsets, field positions and fixed counts of the command sequencer
// Assumes: 32-bit APB data, 12-bit register contents in the low bits
// Notes: definitions only
`ifndef DCS_REGS_SVH
`define DCS_REGS_SVH
// -----------------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------------
`define DCS_OFF_MEMPTR 12'h000
`define DCS_OFF_SECTOR 12'h004
`define DCS_OFF_WCOUNT 12'h008
`define DCS_OFF_CMDA 12'h00c
`define DCS_OFF_CMDB 12'h010
`define DCS_OFF_STATUS 12'h014
`define DCS_OFF_SILO 12'h018
// -----------------------------------------------------------------------
// fields of command register b, a and the sector register
// -----------------------------------------------------------------------
`define DCS_B_FUNC 11:9
`define DCS_B_MAINT 8
`define DCS_B_MODE8 7
`define DCS_B_IE 6
`define DCS_B_DRIVE 5:4
`define DCS_B_EXT 2:0
`define DCS_A_CYL 9:0
`define DCS_SA_SEC 5:0
`define DCS_WORD_BITS 11:0
`define DCS_WORD0 12'h000
// -----------------------------------------------------------------------
// silo, crc and sector framing
// -----------------------------------------------------------------------
`define DCS_SILO_AW 4
`define DCS_SILO_LIM 5'd15
`define DCS_CRC_INIT 16'hffff
`define DCS_CRC_POLY 16'h1021
`define DCS_CRC_GOOD 16'h0000
`define DCS_HDR_LAST 3'd5
`define DCS_DAT_LAST 9'd255
`define DCS_CRC_HI 9'd256
`define DCS_SEC_LAST 9'd257
`define DCS_SEC_END 9'd258
`endif

// file: dcs_pkg.sv
// Purpose: types shared by the command sequencer
// Assumes: dcs_regs.svh gives the silo address width
// Notes: all block state except the silo storage is one packed struct
`include "dcs_regs.svh"
package dcs_pkg;
  typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_SEND = 3'b001, ST_PAIR = 3'b010,
    ST_STAT = 3'b011, ST_HDR = 3'b100, ST_RDAT = 3'b101, ST_WDAT = 3'b110,
    ST_DRN = 3'b111} dcs_state_t;
  typedef enum logic [2:0] {FN_MAINT = 3'b000, FN_RESET = 3'b001, FN_GSTAT = 3'b010,
    FN_SEEK = 3'b011, FN_RHDR = 3'b100, FN_WDAT = 3'b101, FN_RDAT = 3'b110,
    FN_RDNH = 3'b111} dcs_func_t;
  typedef struct packed {logic req; logic we; logic [14:0] addr; logic [11:0] wdata;} dcs_dma_t;
  typedef struct packed {logic valid; logic [7:0] data;} dcs_byte_t;
  typedef struct packed {logic valid; logic [15:0] word;} dcs_word_t;
  typedef struct packed {
    dcs_state_t state;
    dcs_state_t nxt;
    logic [31:0] prdata;
    logic pready, pslverr, irq;
    logic [11:0] memptr, sector, wc, wpush, cmda, cmdb;
    logic busy, done, operation_incomplete_error, hcrc, dcrc, dlt, xfer_on, push_on, first;
    logic [15:0] dcw;
    dcs_word_t cmd;
    dcs_dma_t dma;
    dcs_byte_t tx;
    logic [2:0] hidx;
    logic [15:0] haddr;
    logic [15:0] crc;
    logic [7:0] hcnt;
    logic [8:0] bidx;
    logic [1:0] ph;
    logic [11:0] hold;
    logic [`DCS_SILO_AW:0] wptr, rptr;
  } dcs_st_t;
endpackage

// file: dcs_drive_model.sv
// Purpose: drive, disk and memory partner of the command sequencer
// Assumes: every partner action is synchronous to pclk
// Notes: released data lines show the inverse of their last value
`timescale 1ns/10ps
module dcs_drive_model import dcs_pkg::*; (
  input wire logic pclk,
  input wire logic presetn,
  input wire dcs_word_t drv_cmd,
  output logic drv_cmd_ready,
  output dcs_word_t drv_stat,
  output dcs_byte_t dsk_rx,
  output logic dsk_rx_sof,
  output logic dsk_tx_ready,
  input wire dcs_dma_t dma,
  output logic dma_ack,
  output logic [11:0] dma_rdata
);
  logic [11:0] mem [0:255];
  logic [15:0] last_cmd;
  int sdly;
  int dd;
  // the disk sink never stalls
  assign dsk_tx_ready = 1'b1;
  // -----------------------------------------------------------------------
  // drive link and memory
  // -----------------------------------------------------------------------
  // take each command a cycle late, answer status a few cycles later
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      drv_cmd_ready <= 1'b0;
      drv_stat <= '0;
      sdly <= 0;
      dd <= 0;
      dma_ack <= 1'b0;
      dma_rdata <= '0;
    end else begin
      drv_cmd_ready <= drv_cmd.valid && !drv_cmd_ready;
      if (drv_cmd.valid && drv_cmd_ready) begin
        last_cmd <= drv_cmd.word;
        sdly <= 4;
      end else if (sdly != 0) begin
        sdly <= sdly - 1;
      end
      drv_stat.valid <= (sdly == 1);
      drv_stat.word <= (sdly == 1) ? 16'ha5c3 : ~drv_stat.word;
      dma_ack <= 1'b0;
      dma_rdata <= ~dma_rdata;
      if (dma.req && !dma_ack) begin
        dd <= (dd == 2) ? 0 : dd + 1;
      end
      if (dma.req && !dma_ack && dd == 2) begin
        dma_ack <= 1'b1;
        dma_rdata <= mem[dma.addr[7:0]];
        if (dma.we) begin
          mem[dma.addr[7:0]] <= dma.wdata;
        end
      end
    end
  end
  // one disk byte, then the line is released
  task automatic send_byte(input logic [7:0] b, input logic sof);
    dsk_rx <= '{1'b1, b};
    dsk_rx_sof <= sof;
    @(posedge pclk);
    dsk_rx <= '{1'b0, ~b};
    dsk_rx_sof <= 1'b0;
    @(posedge pclk);
  endtask
  initial begin
    dsk_rx = '0;
    dsk_rx_sof = 1'b0;
  end
endmodule

// file: testbench.sv
// Purpose: self-checking bench of the command sequencer
// Assumes: drive partner in dcs_drive_model, three header tries allowed
// Notes: one task per scenario, verdict in give_verdict
`timescale 1ns/10ps
`include "dcs_regs.svh"
module testbench import dcs_pkg::*;;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, drv_cmd_ready;
  logic dsk_rx_sof, dsk_tx_ready, dma_ack, errv;
  logic [11:0] paddr, dma_rdata;
  logic [31:0] pwdata, prdata, rdv;
  dcs_word_t drv_cmd, drv_stat;
  dcs_byte_t dsk_rx, dsk_tx;
  dcs_dma_t dma;
  logic [7:0] hb [0:5];
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  dcs_top #(.HDR_LIMIT(8'd3)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .drv_cmd(drv_cmd),
    .drv_cmd_ready(drv_cmd_ready), .drv_stat(drv_stat), .dsk_rx(dsk_rx),
    .dsk_rx_sof(dsk_rx_sof), .dsk_tx(dsk_tx), .dsk_tx_ready(dsk_tx_ready), .dma(dma),
    .dma_ack(dma_ack), .dma_rdata(dma_rdata));
  dcs_drive_model u_drv (.pclk(pclk), .presetn(presetn), .drv_cmd(drv_cmd),
    .drv_cmd_ready(drv_cmd_ready), .drv_stat(drv_stat), .dsk_rx(dsk_rx),
    .dsk_rx_sof(dsk_rx_sof), .dsk_tx_ready(dsk_tx_ready), .dma(dma), .dma_ack(dma_ack),
    .dma_rdata(dma_rdata));
  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) n_errors++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      apb(1'b0, `DCS_OFF_STATUS, 32'h0);
      n++;
    end while (rdv[1] !== 1'b1 && n < 400);
    if (rdv[1] !== 1'b1) n_errors++;
  endtask
  task automatic start(input logic [11:0] cyl, sec, input logic [2:0] f, input logic mt, ie);
    apb(1'b1, `DCS_OFF_SECTOR, {20'h0, sec});
    apb(1'b1, `DCS_OFF_CMDA, {20'h0, cyl});
    apb(1'b1, `DCS_OFF_CMDB, {20'h0, f, mt, 1'b1, ie, 2'd1, 4'h0});
  endtask
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) c = c[15] ? ((c << 1) ^ `DCS_CRC_POLY) : (c << 1);
    return c;
  endfunction
  task automatic send_hdr(input logic [15:0] a);
    logic [15:0] c;
    hb = '{a[15:8], a[7:0], 8'h00, 8'h00, 8'h00, 8'h00};
    c = `DCS_CRC_INIT;
    for (int i = 0; i < 4; i++) c = crc_upd(c, hb[i]);
    hb[4] = c[15:8];
    hb[5] = c[7:0];
    for (int i = 0; i < 6; i++) u_drv.send_byte(hb[i], i == 0);
  endtask
  // -----------------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------------
  task automatic t_regs();
    apb(1'b0, `DCS_OFF_STATUS, 32'h0);
    chk("status at reset", rdv, 32'h1);
    apb(1'b1, `DCS_OFF_MEMPTR, 32'hffff_fabc);
    apb(1'b0, `DCS_OFF_MEMPTR, 32'h0);
    chk("memptr", rdv, 32'h0abc);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped error", {31'h0, errv}, 32'h1);
    $display("test regs done");
  endtask
  task automatic t_gstat();
    start(12'h0, 12'h0, FN_GSTAT, 1'b0, 1'b1);
    apb(1'b1, `DCS_OFF_MEMPTR, 32'h123);
    wait_done();
    chk("irq", {31'h0, irq}, 32'h1);
    apb(1'b0, `DCS_OFF_MEMPTR, 32'h0);
    chk("busy load", rdv, 32'habc);
    apb(1'b0, `DCS_OFF_SILO, 32'h0);
    chk("status hi", rdv, 32'h0a5);
    apb(1'b0, `DCS_OFF_SILO, 32'h0);
    chk("status lo", rdv, 32'h0c3);
    $display("test get status done");
  endtask
  task automatic t_seek();
    start(12'h2a5, 12'h0, FN_SEEK, 1'b1, 1'b0);
    wait_done();
    chk("ready", {31'h0, rdv[0]}, 32'h1);
    chk("cmd word", {16'h0, u_drv.last_cmd}, 32'h02a7);
    chk("irq off", {31'h0, irq}, 32'h0);
    apb(1'b0, `DCS_OFF_SILO, 32'h0);
    chk("loop hi", rdv, {24'h0, u_drv.last_cmd[15:8]});
    apb(1'b0, `DCS_OFF_SILO, 32'h0);
    chk("loop lo", rdv, {24'h0, u_drv.last_cmd[7:0]});
    $display("test seek done");
  endtask
  task automatic t_rhdr();
    start(12'h0, 12'h0, FN_RHDR, 1'b0, 1'b0);
    repeat (10) @(posedge pclk);
    u_drv.send_byte(8'h77, 1'b0);
    send_hdr(16'h1234);
    wait_done();
    chk("header crc flag", {31'h0, rdv[3]}, 32'h0);
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, `DCS_OFF_SILO, 32'h0);
      chk("header byte", rdv, {24'h0, hb[i]});
    end
    $display("test read header done");
  endtask
  task automatic t_read(input logic [2:0] f, input logic [11:0] cyl, ptr, input logic ok);
    logic [15:0] c;
    apb(1'b1, `DCS_OFF_MEMPTR, {20'h0, ptr});
    apb(1'b1, `DCS_OFF_WCOUNT, 32'hfff);
    start(cyl, 12'h7, f, 1'b0, 1'b0);
    repeat (10) @(posedge pclk);
    repeat (ok ? 1 : 3) send_hdr({10'd5, 6'd7});
    c = `DCS_CRC_INIT;
    for (int i = 0; i < 256 && ok; i++) begin
      c = crc_upd(c, i[7:0] ^ 8'h5a);
      u_drv.send_byte(i[7:0] ^ 8'h5a, 1'b0);
    end
    if (ok) u_drv.send_byte(c[15:8], 1'b0);
    if (ok) u_drv.send_byte(c[7:0], 1'b0);
    wait_done();
    chk("errors", rdv & 32'h1c, ok ? 32'h0 : 32'h4);
    if (ok) begin
      chk("dma word", {20'h0, u_drv.mem[ptr[7:0]]}, 32'h05a);
      apb(1'b0, `DCS_OFF_MEMPTR, 32'h0);
      chk("pointer step", rdv, {20'h0, ptr + 12'h1});
    end
    $display("test read done");
  endtask
  // -----------------------------------------------------------------------
  // clock, reset, timeout and main sequence
  // -----------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // cut a hang short
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      give_verdict();
    end
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_gstat();
    t_seek();
    t_rhdr();
    t_read(FN_RDAT, 12'd5, 12'h020, 1'b1);
    t_read(FN_RDNH, 12'd9, 12'h030, 1'b1);
    t_read(FN_RDAT, 12'd9, 12'h040, 1'b0);
    give_verdict();
  end
endmodule
